// file: ecg_buf.sv
`timescale 1ns/1ps
`default_nettype none
module ecg_buf
	import ecg_pkg::*;
#(
	parameter type T = ecg_result_s
)
(
	// Clock and reset.
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	// Filling side.
	input  wire logic in_valid_i,
	input  wire T     in_data_i,
	output logic      in_ready_o,
	// Draining side.
	output logic      out_valid_o,
	input  wire logic out_ready_i,
	output T          out_data_o
);
	typedef struct packed
	{
		logic hv;
		T     h;
		logic tv;
		T     t;
	} ecg_buf_s;

	ecg_buf_s r;
	ecg_buf_s n;

	// The head entry drives the output directly so no mux sits between the head register and the output.
	always_comb
	begin
		n = r;
		if (r.hv && out_ready_i)
		begin
			if (r.tv)
			begin
				n.h  = r.t;
				n.tv = 1'b0;
			end
			else
				n.hv = 1'b0;
		end
		if (in_valid_i && !r.tv)
		begin
			if (!n.hv)
			begin
				n.h  = in_data_i;
				n.hv = 1'b1;
			end
			else
			begin
				n.t  = in_data_i;
				n.tv = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
			r <= '0;
		else
			r <= n;
	end

	assign in_ready_o  = !r.tv;
	assign out_valid_o = r.hv;
	assign out_data_o  = r.h;
endmodule : ecg_buf
`default_nettype wire

// file: ecg_core.sv
// Operation
// RULE1 - Test data out changes on test clock fall.
// RULE2 - Test data out floats unless scanning.
// RULE3 - Test reset low forces Test-Logic-Reset.
// RULE4 - Device reset low holds standby.
// RULE5 - Release runs initialization loading defaults.
// RULE6 - Sixteen groups, two cancellers each.
// RULE7 - Normal: two independent 64 ms cancellers.
// RULE8 - Extended: cascaded 128 ms single channel.
// RULE9 - Back-to-back: one channel, both directions.
// RULE10 - Canceller states: mute, bypass, frozen, adapting.
// RULE11 - 1024 taps in two 512-tap sections.
// RULE12 - Section mapping for normal and extended.
// RULE13 - Back-to-back: receive first, transmit second.
// RULE14 - Output is send input minus estimate.
// RULE15 - Double-talk when send exceeds scaled receive.
// RULE16 - Double-talk freezes adaptation, cancelling continues.
// RULE17 - Uncertain talk slows adaptation.
// RULE18 - Threshold defaults to 4800h.
// RULE19 - Threshold is 16-bit fraction times 32768.
// RULE20 - Group configuration changes both cancellers together.
`timescale 1ns/1ps
`default_nettype none
module ecg_core
	import ecg_pkg::*;
#(
	parameter int unsigned GROUPS   = ECG_GROUPS,
	parameter int unsigned TAPS     = ECG_TAPS,
	parameter int unsigned SEC_TAPS = ECG_SEC_TAPS
)
(
	// Clock and resets.
	input  wire logic                 ref_clk_i,
	input  wire logic                 reset_i,
	input  wire logic                 dev_reset_n_i,
	// Test access port.
	input  wire logic                 tck_i,
	input  wire logic                 tms_i,
	input  wire logic                 tdi_i,
	input  wire logic                 trst_n_i,
	output logic                      tdo_o,
	output logic                      tdo_oe_o,
	// Sample link.
	input  wire logic                 link_clk_i,
	input  wire logic                 link_valid_i,
	input  wire ecg_word_s            link_word_i,
	// Host control.
	input  wire logic                 thr_we_i,
	input  wire logic [15:0]          thr_wdata_i,
	input  wire logic                 cfg_we_i,
	input  wire logic [ECG_GRP_W-1:0] cfg_group_i,
	input  wire ecg_group_cfg_s       cfg_i,
	output logic [15:0]               thr_o,
	output logic                      init_busy_o,
	output logic                      standby_o,
	output logic                      overrun_o,
	// Cancelled output stream.
	output logic                      out_valid_o,
	input  wire logic                 out_ready_i,
	output ecg_result_s               out_data_o
);
	localparam int TAP_W = $clog2(TAPS);

	typedef struct packed
	{
		logic [1:0]                              dev_rst_n_q;
		logic [1:0]                              tck_q;
		logic [1:0]                              tms_q;
		logic [1:0]                              tdi_q;
		logic [1:0]                              trst_n_q;
		logic [1:0]                              lclk_q;
		logic [1:0]                              lvalid_q;
		ecg_word_s [1:0]                         lword_q;
		logic                                    tck_prev;
		logic                                    lclk_prev;
		ecg_tap_e                                tap;
		logic [ECG_IR_W-1:0]                     ir_sh;
		logic                                    byp;
		logic                                    tdo;
		logic                                    tdo_oe;
		logic                                    standby;
		logic                                    init_busy;
		logic [TAP_W-1:0]                        init_idx;
		logic [15:0]                             thr;
		ecg_group_cfg_s [GROUPS-1:0]             cfg;
		logic                                    pend_v;
		ecg_word_s                               pend;
		logic                                    overrun;
		ecg_proc_e                               proc;
		ecg_word_s                               cur;
		ecg_ec_e                                 ec;
		logic                                    ext;
		logic [TAP_W-1:0]                        base;
		logic [TAP_W-1:0]                        mask;
		logic [TAP_W-1:0]                        k;
		logic signed [ECG_ACC_W-1:0]             acc;
		logic [15:0]                             err;
		logic                                    dt;
		logic                                    slow;
		logic [GROUPS-1:0][1:0][TAP_W-1:0]       ptr;
		logic [GROUPS-1:0][1:0][15:0]            lvl_ref;
		logic [GROUPS-1:0][1:0][15:0]            lvl_near;
		logic [GROUPS-1:0][TAPS-1:0][15:0]       coef;
		logic [GROUPS-1:0][TAPS-1:0][15:0]       hist;
	} ecg_core_s;

	ecg_core_s r;
	ecg_core_s n;

	function automatic logic [15:0] ecg_sat(input logic signed [ECG_ACC_W-1:0] v);
		logic signed [ECG_ACC_W-1:0] hi;
		logic signed [ECG_ACC_W-1:0] lo;
		hi = ECG_ACC_W'($signed(ECG_SMP_MAX));
		lo = ECG_ACC_W'($signed(ECG_SMP_MIN));
		if (v > hi)
			return ECG_SMP_MAX;
		else if (v < lo)
			return ECG_SMP_MIN;
		return v[15:0];
	endfunction : ecg_sat

	// Peak follower: the decay keeps the level responsive without a true power estimate.
	function automatic logic [15:0] ecg_level(input logic [15:0] old, input logic [15:0] smp);
		logic [15:0] mag;
		logic [15:0] dec;
		mag = smp[15] ? 16'(-smp) : smp;
		dec = old - (old >> ECG_LVL_DECAY);
		return (mag > dec) ? mag : dec;
	endfunction : ecg_level

	function automatic ecg_tap_e ecg_tap_next(input ecg_tap_e s, input logic tms);
		case (s)
			ECG_TLR:      return tms ? ECG_TLR : ECG_RTI;
			ECG_RTI:      return tms ? ECG_SEL_DR : ECG_RTI;
			ECG_SEL_DR:   return tms ? ECG_SEL_IR : ECG_CAP_DR;
			ECG_CAP_DR:   return tms ? ECG_EXIT1_DR : ECG_SHIFT_DR;
			ECG_SHIFT_DR: return tms ? ECG_EXIT1_DR : ECG_SHIFT_DR;
			ECG_EXIT1_DR: return tms ? ECG_UPD_DR : ECG_PAUSE_DR;
			ECG_PAUSE_DR: return tms ? ECG_EXIT2_DR : ECG_PAUSE_DR;
			ECG_EXIT2_DR: return tms ? ECG_UPD_DR : ECG_SHIFT_DR;
			ECG_SEL_IR:   return tms ? ECG_TLR : ECG_CAP_IR;
			ECG_CAP_IR:   return tms ? ECG_EXIT1_IR : ECG_SHIFT_IR;
			ECG_SHIFT_IR: return tms ? ECG_EXIT1_IR : ECG_SHIFT_IR;
			ECG_EXIT1_IR: return tms ? ECG_UPD_IR : ECG_PAUSE_IR;
			ECG_PAUSE_IR: return tms ? ECG_EXIT2_IR : ECG_PAUSE_IR;
			ECG_EXIT2_IR: return tms ? ECG_UPD_IR : ECG_SHIFT_IR;
			default:      return tms ? ECG_SEL_DR : ECG_RTI;
		endcase
	endfunction : ecg_tap_next

	logic [ECG_GRP_W-1:0]        g;
	logic                        sec;
	logic [TAP_W-1:0]            wp;
	logic [TAP_W-1:0]            idx;
	logic [TAP_W-1:0]            cidx;
	logic [15:0]                 hx;
	logic [15:0]                 cx;
	logic signed [31:0]          prod;
	logic signed [31:0]          upd;
	logic signed [31:0]          step;
	logic signed [ECG_ACC_W-1:0] sum;
	logic [15:0]                 new_err;
	logic [15:0]                 new_coef;
	logic [15:0]                 nl;
	logic [15:0]                 rl;
	logic [31:0]                 rhs;
	logic                        dt_c;
	logic                        slow_c;
	logic                        tck_rise;
	logic                        tck_fall;
	logic                        lclk_rise;
	logic                        shifting;
	logic [15:0]                 out_smp_c;
	ecg_result_s                 res_c;
	logic                        emit_v;
	logic                        buf_ready;
	ecg_group_cfg_s              pcfg;

	assign tck_rise  = r.tck_q[1] && !r.tck_prev;
	assign tck_fall  = !r.tck_q[1] && r.tck_prev;
	assign lclk_rise = r.lclk_q[1] && !r.lclk_prev;
	assign shifting  = (r.tap == ECG_SHIFT_DR) || (r.tap == ECG_SHIFT_IR);

	// In extended mode both sections form one ring, so the second section delays the first.
	assign g    = r.cur.group;
	assign sec  = r.cur.chan && !r.ext;
	assign wp   = TAP_W'((r.ptr[g][sec] + 1'b1) & r.mask);
	assign idx  = TAP_W'(r.base + ((r.ptr[g][sec] - r.k) & r.mask));
	assign cidx = TAP_W'(r.base + r.k);
	assign hx   = r.hist[g][idx];
	assign cx   = r.coef[g][cidx];
	assign prod = $signed(cx) * $signed(hx);
	assign sum  = r.acc + ECG_ACC_W'(prod);
	assign new_err = ecg_sat(ECG_ACC_W'($signed(r.cur.near_smp)) - (sum >>> ECG_Q_SHIFT)); // RULE14
	assign upd  = $signed(r.err) * $signed(hx);
	assign step = r.slow ? (upd >>> ECG_MU_SLOW) : (upd >>> ECG_MU_FAST); // RULE17
	assign new_coef = ecg_sat(ECG_ACC_W'($signed(cx)) + ECG_ACC_W'(step));

	// Comparing scaled amplitudes avoids a logarithm: near > ref * thr / 32768.
	assign nl     = ecg_level(r.lvl_near[g][r.cur.chan], r.cur.near_smp);
	assign rl     = ecg_level(r.lvl_ref[g][r.cur.chan], r.cur.ref_smp);
	assign rhs    = 32'(rl) * 32'(r.thr); // RULE19
	assign dt_c   = (32'(nl) << ECG_Q_SHIFT) > rhs; // RULE15
	assign slow_c = !dt_c && ((32'(nl) << (ECG_Q_SHIFT + 1)) > rhs); // RULE17

	assign out_smp_c = (r.ec == ECG_MUTE) ? '0 : (r.ec == ECG_BYPASS) ? r.cur.near_smp : r.err; // RULE10
	assign res_c     = '{r.cur.group, r.cur.chan, out_smp_c, r.dt};
	assign emit_v    = (r.proc == ECG_EMIT);
	assign pcfg      = r.cfg[r.pend.group];

	always_comb
	begin
		n = r;
		n.dev_rst_n_q = {r.dev_rst_n_q[0], dev_reset_n_i};
		n.tck_q       = {r.tck_q[0], tck_i};
		n.tms_q       = {r.tms_q[0], tms_i};
		n.tdi_q       = {r.tdi_q[0], tdi_i};
		n.trst_n_q    = {r.trst_n_q[0], trst_n_i};
		n.lclk_q      = {r.lclk_q[0], link_clk_i};
		n.lvalid_q    = {r.lvalid_q[0], link_valid_i};
		n.lword_q     = {r.lword_q[0], link_word_i};
		n.tck_prev    = r.tck_q[1];
		n.lclk_prev   = r.lclk_q[1];

		if (tck_rise)
		begin
			case (r.tap)
				ECG_CAP_IR:   n.ir_sh = ECG_IR_CAPTURE;
				ECG_SHIFT_IR: n.ir_sh = {r.tdi_q[1], r.ir_sh[ECG_IR_W-1:1]};
				ECG_CAP_DR:   n.byp = 1'b0;
				ECG_SHIFT_DR: n.byp = r.tdi_q[1];
				default:      n.byp = r.byp;
			endcase
			n.tap = ecg_tap_next(r.tap, r.tms_q[1]);
		end
		if (tck_fall)
		begin
			n.tdo_oe = shifting; // RULE2
			n.tdo    = (r.tap == ECG_SHIFT_IR) ? r.ir_sh[0] : r.byp; // RULE1
		end
		if (!r.trst_n_q[1])
		begin
			n.tap    = ECG_TLR; // RULE3
			n.tdo_oe = 1'b0;
		end

		case (r.proc)
			ECG_IDLE:
				if (r.pend_v && !r.init_busy)
				begin
					n.pend_v = 1'b0;
					n.cur    = r.pend;
					n.ext    = (pcfg.mode == ECG_EXTENDED); // RULE8
					n.ec     = r.pend.chan ? pcfg.canceller_second : pcfg.canceller_first; // RULE6
					n.base   = (r.pend.chan && pcfg.mode != ECG_EXTENDED) ? TAP_W'(SEC_TAPS) : '0; // RULE12 RULE13
					n.mask   = n.ext ? TAP_W'(TAPS - 1) : TAP_W'(SEC_TAPS - 1); // RULE11 RULE7 RULE9
					n.proc   = ECG_LOAD;
					if (n.ext && r.pend.chan)
					begin
						// The second canceller is absorbed into the cascade and passes its word through.
						n.ec   = ECG_BYPASS; // RULE8
						n.proc = ECG_EMIT;
					end
				end
			ECG_LOAD:
			begin
				n.ptr[g][sec]              = wp;
				n.hist[g][TAP_W'(r.base + wp)] = r.cur.ref_smp;
				n.lvl_near[g][r.cur.chan]  = nl;
				n.lvl_ref[g][r.cur.chan]   = rl;
				n.dt   = dt_c; // RULE15
				n.slow = slow_c;
				n.k    = '0;
				n.acc  = '0;
				n.proc = ECG_FILTER;
			end
			ECG_FILTER:
			begin
				n.acc = sum;
				n.k   = TAP_W'(r.k + 1'b1);
				if (r.k == r.mask)
				begin
					n.err  = new_err; // RULE14
					n.k    = '0;
					n.proc = (r.ec == ECG_ADAPT_ON && !r.dt) ? ECG_ADAPT : ECG_EMIT; // RULE16 RULE10
				end
			end
			ECG_ADAPT:
			begin
				n.coef[g][cidx] = new_coef;
				n.k = TAP_W'(r.k + 1'b1);
				if (r.k == r.mask)
					n.proc = ECG_EMIT;
			end
			ECG_EMIT:
				if (buf_ready)
					n.proc = ECG_IDLE;
			default:
				n.proc = ECG_IDLE;
		endcase

		// Clearing one tap index per cycle keeps the sweep cheap at the cost of TAPS cycles.
		if (r.init_busy)
		begin
			for (int gi = 0; gi < GROUPS; gi++)
			begin
				n.coef[gi][r.init_idx] = '0; // RULE5
				n.hist[gi][r.init_idx] = '0;
			end
			n.ptr      = '0;
			n.lvl_ref  = '0;
			n.lvl_near = '0;
			n.init_idx = TAP_W'(r.init_idx + 1'b1);
			if (r.init_idx == TAP_W'(TAPS - 1))
				n.init_busy = 1'b0;
		end
		else
		begin
			if (thr_we_i)
				n.thr = thr_wdata_i; // RULE19
			if (cfg_we_i)
				n.cfg[cfg_group_i] = cfg_i; // RULE20
		end

		// A word arriving while the pending slot is taken sets the flag; set wins over take.
		if (lclk_rise && r.lvalid_q[1])
		begin
			if (n.pend_v)
				n.overrun = 1'b1;
			n.pend_v = 1'b1;
			n.pend   = r.lword_q[1];
		end

		n.standby = !r.dev_rst_n_q[1];
		if (!r.dev_rst_n_q[1])
		begin
			n.init_busy = 1'b1; // RULE4
			n.init_idx  = '0;
			n.thr       = ECG_THR_RESET; // RULE18
			n.cfg       = {GROUPS{ECG_CFG_RESET}};
			n.proc      = ECG_IDLE;
			n.pend_v    = 1'b0;
			n.overrun   = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			r           <= '0;
			r.standby   <= 1'b1;
			r.init_busy <= 1'b1;
			r.thr       <= ECG_THR_RESET;
			r.cfg       <= {GROUPS{ECG_CFG_RESET}};
		end
		else
			r <= n;
	end

	ecg_buf #(
		.T(ecg_result_s)
	) u_out_buf (
		.ref_clk_i  (ref_clk_i),
		.reset_i    (reset_i),
		.in_valid_i (emit_v),
		.in_data_i  (res_c),
		.in_ready_o (buf_ready),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o (out_data_o)
	);

	assign tdo_o       = r.tdo;
	assign tdo_oe_o    = r.tdo_oe;
	assign thr_o       = r.thr;
	assign init_busy_o = r.init_busy;
	assign standby_o   = r.standby;
	assign overrun_o   = r.overrun;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	tdo_fall_edge_a: assert property ($changed(r.tdo) |-> $past(tck_fall)) // RULE1
		else $error("Test data out changed away from a test clock fall.");
	tdo_float_a: assert property (r.tdo_oe |-> (r.tap inside {ECG_SHIFT_DR, ECG_EXIT1_DR, // RULE2
		ECG_SHIFT_IR, ECG_EXIT1_IR}))
		else $error("Test data out driven outside a scan.");
	trst_force_a: assert property (!r.trst_n_q[1] |=> (r.tap == ECG_TLR) && !r.tdo_oe) // RULE3
		else $error("Test reset did not force Test-Logic-Reset.");
	standby_hold_a: assert property (!r.dev_rst_n_q[1] |=> r.standby && r.init_busy && (r.proc == ECG_IDLE)) // RULE4
		else $error("Device reset did not hold standby.");
	init_defaults_a: assert property ($fell(r.init_busy) |-> (r.thr == ECG_THR_RESET) // RULE5
		&& ($past(r.init_idx) == TAP_W'(TAPS - 1)))
		else $error("Initialization ended early or without defaults.");
	ext_absorb_a: assert property ((r.proc == ECG_IDLE) && r.pend_v && !r.init_busy && r.dev_rst_n_q[1] // RULE8
		&& r.pend.chan && (pcfg.mode == ECG_EXTENDED) |=> (r.proc == ECG_EMIT) && (r.ec == ECG_BYPASS))
		else $error("Extended group did not absorb its second canceller.");
	span_len_a: assert property ((r.proc == ECG_LOAD) |-> // RULE11
		r.mask == (r.ext ? TAP_W'(TAPS - 1) : TAP_W'(SEC_TAPS - 1)))
		else $error("Filter span does not match configuration.");
	mute_out_a: assert property (emit_v && (r.ec == ECG_MUTE) |-> (res_c.out_smp == '0)) // RULE10
		else $error("Muted canceller produced a sample.");
	emit_err_a: assert property (emit_v && (r.ec inside {ECG_ADAPT_OFF, ECG_ADAPT_ON}) // RULE14
		|-> (res_c.out_smp == r.err))
		else $error("Output is not the cancelled send sample.");
	dt_freeze_a: assert property ((r.proc == ECG_ADAPT) |-> !r.dt && (r.ec == ECG_ADAPT_ON)) // RULE16
		else $error("Coefficients adapted during double-talk.");
	thr_write_a: assert property (thr_we_i && !r.init_busy && r.dev_rst_n_q[1] // RULE19
		|=> (r.thr == $past(thr_wdata_i)))
		else $error("Threshold write was lost.");
	cfg_pair_a: assert property (cfg_we_i && !r.init_busy && r.dev_rst_n_q[1] // RULE20
		|=> (r.cfg[$past(cfg_group_i)] == $past(cfg_i)))
		else $error("Group configuration write was lost.");
endmodule : ecg_core
`default_nettype wire

// file: ecg_link_src.sv
`timescale 1ns/1ps
`default_nettype none
module ecg_link_src
	import ecg_pkg::*;
(
	// Link pins towards the core.
	output logic      link_clk_o,
	output logic      link_valid_o,
	output ecg_word_s link_word_o
);
	initial
	begin
		link_clk_o   = 1'b0;
		link_valid_o = 1'b0;
		link_word_o  = '0;
	end

	// The link clock only runs inside a frame. Released data shows the inverse
	// of the last word, so that a stale word can never pass for a fresh one.
	task automatic send(input ecg_word_s w);
		link_word_o  = w;
		link_valid_o = 1'b1;
		#80 link_clk_o = 1'b1;
		#80 link_clk_o = 1'b0;
		link_valid_o = 1'b0;
		link_word_o  = ~w;
	endtask : send
endmodule : ecg_link_src
`default_nettype wire

// file: ecg_pkg.sv
`default_nettype none
package ecg_pkg;
	localparam int unsigned ECG_GROUPS    = 16;
	localparam int unsigned ECG_SEC_TAPS  = 512;
	localparam int unsigned ECG_TAPS      = 1024;
	localparam int unsigned ECG_GRP_W     = 4;
	localparam int unsigned ECG_ACC_W     = 42;
	localparam int unsigned ECG_Q_SHIFT   = 15;
	localparam int unsigned ECG_MU_FAST   = 12;
	localparam int unsigned ECG_MU_SLOW   = 15;
	localparam int unsigned ECG_LVL_DECAY = 6;
	localparam int unsigned ECG_IR_W      = 2;
	localparam logic [15:0] ECG_THR_RESET = 16'h4800;
	localparam logic [15:0] ECG_SMP_MAX   = 16'h7FFF;
	localparam logic [15:0] ECG_SMP_MIN   = 16'h8000;
	localparam logic [ECG_IR_W-1:0] ECG_IR_CAPTURE = 2'h1;

	typedef enum logic [1:0]
	{
		ECG_NORMAL    = 2'h0,
		ECG_EXTENDED  = 2'h1,
		ECG_BACK2BACK = 2'h2
	} ecg_mode_e;

	typedef enum logic [1:0]
	{
		ECG_MUTE      = 2'h0,
		ECG_BYPASS    = 2'h1,
		ECG_ADAPT_OFF = 2'h2,
		ECG_ADAPT_ON  = 2'h3
	} ecg_ec_e;

	typedef enum logic [2:0]
	{
		ECG_IDLE   = 3'h0,
		ECG_LOAD   = 3'h1,
		ECG_FILTER = 3'h3,
		ECG_ADAPT  = 3'h2,
		ECG_EMIT   = 3'h6
	} ecg_proc_e;

	typedef enum logic [3:0]
	{
		ECG_TLR      = 4'h0, ECG_RTI      = 4'h1, ECG_SEL_DR   = 4'h3, ECG_CAP_DR   = 4'h2,
		ECG_SHIFT_DR = 4'h6, ECG_EXIT1_DR = 4'h7, ECG_PAUSE_DR = 4'h5, ECG_EXIT2_DR = 4'h4,
		ECG_UPD_DR   = 4'hC, ECG_SEL_IR   = 4'hD, ECG_CAP_IR   = 4'hF, ECG_SHIFT_IR = 4'hE,
		ECG_EXIT1_IR = 4'hA, ECG_PAUSE_IR = 4'hB, ECG_EXIT2_IR = 4'h9, ECG_UPD_IR   = 4'h8
	} ecg_tap_e;

	typedef struct packed
	{
		logic [ECG_GRP_W-1:0] group;
		logic                 chan;
		logic [15:0]          ref_smp;
		logic [15:0]          near_smp;
	} ecg_word_s;

	typedef struct packed
	{
		logic [ECG_GRP_W-1:0] group;
		logic                 chan;
		logic [15:0]          out_smp;
		logic                 dbl_talk;
	} ecg_result_s;

	typedef struct packed
	{
		ecg_mode_e mode;
		ecg_ec_e   canceller_first;
		ecg_ec_e   canceller_second;
	} ecg_group_cfg_s;

	localparam ecg_group_cfg_s ECG_CFG_RESET = '{ECG_NORMAL, ECG_ADAPT_ON, ECG_ADAPT_ON};
endpackage : ecg_pkg
`default_nettype wire

// file: test_echo_canceller_group_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_echo_canceller_group_core;
	import ecg_pkg::*;
	logic                 ref_clk_i, reset_i, dev_reset_n_i, tck_i, tms_i, tdi_i, trst_n_i;
	logic                 tdo_o, tdo_oe_o, link_clk_i, link_valid_i, thr_we_i, cfg_we_i;
	logic                 init_busy_o, standby_o, overrun_o, out_valid_o, out_ready_i;
	logic [15:0]          thr_wdata_i, thr_o;
	logic [ECG_GRP_W-1:0] cfg_group_i;
	ecg_word_s            link_word_i;
	ecg_group_cfg_s       cfg_i;
	ecg_result_s          out_data_o;
	int                   n_mismatch = 0;
	int                   checks_done = 0;
	ecg_word_s            tw [8] = '{'{0, 0, 16'h0000, 16'h1000}, '{1, 0, 16'h0100, 16'h1234},
		'{1, 1, 16'h0100, 16'h1234}, '{4, 0, 16'h0000, 16'h0ABC}, '{4, 1, 16'h0000, 16'h0ABC},
		'{3, 1, 16'h0200, 16'h2222}, '{2, 0, 16'h0300, 16'h0000}, '{2, 1, 16'h0000, 16'h0555}};
	logic [15:0]          te [8] = '{16'h1000, 16'h0000, 16'h1234, 16'h0ABC, 16'h0000, 16'h2222,
		16'h0000, 16'h0555};
	logic [1:0]           td [8] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1};

	ecg_core #(.GROUPS(16), .TAPS(16), .SEC_TAPS(8)) dut (.ref_clk_i, .reset_i, .dev_reset_n_i,
		.tck_i, .tms_i, .tdi_i, .trst_n_i, .tdo_o, .tdo_oe_o, .link_clk_i, .link_valid_i,
		.link_word_i, .thr_we_i, .thr_wdata_i, .cfg_we_i, .cfg_group_i, .cfg_i, .thr_o,
		.init_busy_o, .standby_o, .overrun_o, .out_valid_o, .out_ready_i, .out_data_o);
	ecg_link_src src (.link_clk_o(link_clk_i), .link_valid_o(link_valid_i), .link_word_o(link_word_i));

	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic thr_w(input logic [15:0] v);
		thr_wdata_i = v;
		thr_we_i    = 1'b1;
		tick(1);
		thr_we_i    = 1'b0;
		tick(1);
	endtask : thr_w

	task automatic cfg_w(input logic [3:0] g, input ecg_group_cfg_s c);
		cfg_group_i = g;
		cfg_i       = c;
		cfg_we_i    = 1'b1;
		tick(1);
		cfg_we_i    = 1'b0;
		tick(1);
	endtask : cfg_w

	task automatic wait_init;
		int k;
		k = 0;
		while (init_busy_o !== 1'b0 && k < 3000)
		begin
			tick(1);
			k++;
		end
		chk({15'h0, init_busy_o}, 16'h0, "init finished");
		chk({15'h0, standby_o}, 16'h0, "standby");
	endtask : wait_init

	// Words are spaced well apart, since one pending slot is all the core has.
	task automatic put(input ecg_word_s w);
		src.send(w);
		tick(45);
	endtask : put

	// The receiver stalls until a result is seen, then takes it for one cycle.
	task automatic get(input logic [15:0] es, input logic [1:0] ed);
		int k;
		k = 0;
		while (out_valid_o !== 1'b1 && k < 300)
		begin
			tick(1);
			k++;
		end
		chk({15'h0, out_valid_o}, 16'h1, "valid");
		chk(out_data_o.out_smp, es, "sample");
		if (ed != 2'h2)
			chk({15'h0, out_data_o.dbl_talk}, {15'h0, ed[0]}, "double talk");
		out_ready_i = 1'b1;
		tick(1);
		out_ready_i = 1'b0;
	endtask : get

	task automatic tap(input logic ms, input logic di);
		tms_i = ms;
		tdi_i = di;
		tick(8);
		tck_i = 1'b1;
		tick(8);
		tck_i = 1'b0;
		tick(4);
	endtask : tap

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	initial
	begin
		#500000;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		n_mismatch++;
		stop_test();
	end

	initial
	begin
		reset_i = 1'b1;
		dev_reset_n_i = 1'b1;
		tck_i = 1'b0;
		tms_i = 1'b1;
		tdi_i = 1'b1;
		trst_n_i = 1'b0;
		thr_we_i = 1'b0;
		thr_wdata_i = '0;
		cfg_we_i = 1'b0;
		cfg_group_i = '0;
		cfg_i = ECG_CFG_RESET;
		out_ready_i = 1'b0;
		tick(8);
		chk(thr_o, 16'h4800, "threshold reset");
		chk({15'h0, standby_o}, 16'h1, "standby in reset");
		chk({15'h0, tdo_oe_o}, 16'h0, "test out enable");
		reset_i = 1'b0;
		trst_n_i = 1'b1;
		wait_init();
		$display("test reset done");
		thr_w(16'h7FFF);
		chk(thr_o, 16'h7FFF, "threshold write");
		dev_reset_n_i = 1'b0;
		tick(4);
		chk({15'h0, standby_o}, 16'h1, "standby held");
		chk(thr_o, 16'h4800, "threshold reloaded");
		dev_reset_n_i = 1'b1;
		tick(5);
		thr_w(16'h1234);
		chk(thr_o, 16'h4800, "write during init");
		wait_init();
		$display("test device reset done");
		cfg_w(1, '{ECG_NORMAL, ECG_MUTE, ECG_BYPASS});
		cfg_w(4, '{ECG_BACK2BACK, ECG_BYPASS, ECG_MUTE});
		cfg_w(3, '{ECG_EXTENDED, ECG_ADAPT_ON, ECG_ADAPT_ON});
		cfg_w(2, '{ECG_NORMAL, ECG_ADAPT_OFF, ECG_ADAPT_OFF});
		for (int i = 0; i < 8; i++)
		begin
			put(tw[i]);
			get(te[i], td[i]);
		end
		$display("test configurations done");
		cfg_w(5, '{ECG_NORMAL, ECG_ADAPT_OFF, ECG_ADAPT_OFF});
		cfg_w(6, '{ECG_NORMAL, ECG_ADAPT_OFF, ECG_ADAPT_OFF});
		thr_w(16'h7FFF);
		put('{5, 0, 16'h0100, 16'h0080});
		get(16'h0080, 2'h0);
		thr_w(16'h2000);
		put('{6, 0, 16'h0100, 16'h0080});
		get(16'h0080, 2'h1);
		$display("test threshold done");
		// Extended group 3 adapts from zero; each word checks the estimate left by the last one.
		put('{3, 0, 16'h4000, 16'h0400});
		get(16'h0400, 2'h0);
		put('{3, 0, 16'h4000, 16'h0400});
		get(16'hFC00, 2'h0);
		put('{3, 0, 16'h4000, 16'h0C00});
		get(16'h1400, 2'h0);
		put('{3, 0, 16'h0000, 16'h0000});
		get(16'hFE00, 2'h0);
		$display("test adaptation done");
		cfg_w(7, '{ECG_NORMAL, ECG_BYPASS, ECG_BYPASS});
		put('{7, 0, 16'h0000, 16'h0011});
		put('{7, 1, 16'h0000, 16'h0022});
		chk({15'h0, overrun_o}, 16'h0, "overrun");
		get(16'h0011, 2'h2);
		get(16'h0022, 2'h2);
		$display("test stall done");
		chk({15'h0, tdo_oe_o}, 16'h0, "test out idle");
		repeat (5) tap(1'b1, 1'b0);
		tap(1'b0, 1'b0);
		tap(1'b1, 1'b0);
		tap(1'b0, 1'b0);
		tap(1'b0, 1'b1);
		chk({15'h0, tdo_oe_o}, 16'h1, "test out shifting");
		tap(1'b0, 1'b1);
		chk({15'h0, tdo_o}, 16'h1, "bypass bit");
		tdi_i = 1'b0;
		tick(8);
		tck_i = 1'b1;
		tick(7);
		chk({15'h0, tdo_o}, 16'h1, "held over rise");
		tck_i = 1'b0;
		tick(4);
		chk({15'h0, tdo_o}, 16'h0, "changed on fall");
		trst_n_i = 1'b0;
		tick(4);
		chk({15'h0, tdo_oe_o}, 16'h0, "test reset");
		trst_n_i = 1'b1;
		$display("test port done");
		stop_test();
	end
endmodule : test_echo_canceller_group_core
`default_nettype wire
